// file: shared/tmr_pkg.sv
// constants and types shared by the task management response dispatch block
`default_nettype none
package tmr_pkg;
    // ****************************************************************
    // register byte offsets on the apb bus
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;   // start and swap flag
    localparam logic [7:0] OFF_RESP = 8'h04;   // service response to report
    localparam logic [7:0] OFF_DEST = 8'h08;   // destination identifier
    localparam logic [7:0] OFF_BUF = 8'h0C;    // location of the built image
    localparam logic [7:0] OFF_RPATH = 8'h10;  // return path identifier
    localparam logic [7:0] OFF_STAT = 8'h14;   // read only status
    localparam logic [7:0] OFF_XOFF = 8'h18;   // transfer offset
    localparam logic [7:0] OFF_XCNT = 8'h1C;   // transfer byte count
    localparam logic [7:0] OFF_XCHAN = 8'h20;  // channel and ordering flag
    localparam logic [7:0] OFF_RXINFO = 8'h24; // last received message info
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_SWAP_BIT = 1;
    localparam int XCHAN_ORDER_BIT = 16;
    // ****************************************************************
    // message codes and fixed field values
    // ****************************************************************
    localparam logic [7:0] MSG_CODE_TMF = 8'h83;    // task management family
    localparam logic [7:0] MSG_CODE_CMD = 8'h80;    // command message
    localparam logic [7:0] MSG_CODE_STAT = 8'h81;   // status message
    localparam logic [7:0] PROTO_RESP = 8'h03;      // function executed response
    localparam logic [7:0] PROTO_ABORT_TASK = 8'h30;
    localparam logic [7:0] PROTO_ABORT_SET = 8'h31;
    localparam logic [7:0] PROTO_CLEAR_QUEUE = 8'h32;
    localparam logic [7:0] PROTO_TGT_RESET = 8'h33;
    localparam logic [7:0] PROTO_CLEAR_ACA = 8'h34;
    localparam logic [7:0] PROTO_LU_RESET = 8'h35;
    localparam logic [7:0] TAG_ZERO = 8'h00;        // tag of every response
    localparam logic [7:0] SEND_CTRL = 8'h00;       // control of every response
    localparam logic [7:0] RESP_LEN = 8'h08;        // bytes in the response image
    localparam logic [7:0] MIN_RX_LEN = 8'h04;      // shortest acceptable payload
    // ****************************************************************
    // return codes on the transport side
    // ****************************************************************
    localparam logic [7:0] RC_SUCCESS = 8'h00;
    localparam logic [7:0] RC_FAILED = 8'h01;
    localparam logic [7:0] RC_INVALID = 8'h02;
    // service response values
    typedef enum logic [1:0] {SR_REJECTED, SR_COMPLETE, SR_FAILURE} svc_resp_t;
    // dispatch classes of a received message
    typedef enum logic [3:0] {
        MT_NONE, MT_COMMAND, MT_STATUS, MT_ABORT_TASK, MT_ABORT_SET,
        MT_CLEAR_ACA, MT_CLEAR_QUEUE, MT_TGT_RESET, MT_LU_RESET, MT_RESPONSE
    } msg_type_t;
endpackage : tmr_pkg
`default_nettype wire

// file: hw/rc_codec.sv
// return code encoder and decoder for service responses
`timescale 1ns/100ps
`default_nettype none
module rc_codec (
    input wire tmr_pkg::svc_resp_t resp_in,
    input wire logic [7:0] rc_in,
    output logic [7:0] rc_out,
    output tmr_pkg::svc_resp_t resp_out
);
    import tmr_pkg::*;
    // ****************************************************************
    // encode direction
    // ****************************************************************
    always_comb begin
        case (resp_in)
            SR_REJECTED: rc_out = RC_INVALID;
            SR_COMPLETE: rc_out = RC_SUCCESS;
            SR_FAILURE: rc_out = RC_FAILED;
            default: rc_out = RC_FAILED;
        endcase
    end
    // ****************************************************************
    // decode direction, unknown codes read as failure
    // ****************************************************************
    always_comb begin
        case (rc_in)
            RC_INVALID: resp_out = SR_REJECTED;
            RC_SUCCESS: resp_out = SR_COMPLETE;
            default: resp_out = SR_FAILURE;
        endcase
    end
endmodule : rc_codec
`default_nettype wire

// file: hw/msg_classifier.sv
// validation and type classification of a received link message
`timescale 1ns/100ps
`default_nettype none
module msg_classifier (
    input wire logic [7:0] code_in,
    input wire logic [7:0] proto_in,
    input wire logic [7:0] len_in,
    output logic valid_out,
    output tmr_pkg::msg_type_t type_out
);
    import tmr_pkg::*;
    // ****************************************************************
    // type lookup, then length check
    // ****************************************************************
    always_comb begin
        type_out = MT_NONE;
        if (code_in == MSG_CODE_CMD) begin
            type_out = MT_COMMAND;
        end else if (code_in == MSG_CODE_STAT) begin
            type_out = MT_STATUS;
        end else if (code_in == MSG_CODE_TMF) begin
            case (proto_in)
                PROTO_RESP: type_out = MT_RESPONSE;
                PROTO_ABORT_TASK: type_out = MT_ABORT_TASK;
                PROTO_ABORT_SET: type_out = MT_ABORT_SET;
                PROTO_CLEAR_QUEUE: type_out = MT_CLEAR_QUEUE;
                PROTO_TGT_RESET: type_out = MT_TGT_RESET;
                PROTO_CLEAR_ACA: type_out = MT_CLEAR_ACA;
                PROTO_LU_RESET: type_out = MT_LU_RESET;
                default: type_out = MT_NONE;
            endcase
        end
        // too short or unknown counts as invalid
        valid_out = (type_out != MT_NONE) && (len_in >= MIN_RX_LEN);
    end
endmodule : msg_classifier
`default_nettype wire

// file: hw/task_mgmt_response_dispatch.sv
// task management response builder and received message dispatcher
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - response uses message code 83h, protocol 03h
// - response tag field always zero
// - service response encoded into return code
// - send control value always zero
// - destination equals answered function's destination
// - pass image location and byte length
// - decode received return code, confirm upward
// - transfer offset is four bytes
// - transfer byte count is four bytes
// - message length is one byte
// - channel value is two bytes
// - transport stores message, reports length, control
// - validate first, then dispatch by type
// - task management request raises indication
// - return path field holds path identifier
// - recognise 83h with protocol 30h to 35h
module task_mgmt_response_dispatch #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // send request to transport
    output logic send_req_out,
    output logic [7:0] send_ctrl_out,
    output logic [15:0] send_dest_out,
    output logic [31:0] send_addr_out,
    output logic [7:0] send_len_out,
    output logic send_swap_out,
    output logic [63:0] send_image_out,
    input wire logic send_ack_in,
    input wire logic [7:0] send_rc_in,
    // transfer parameters to transport
    output logic [31:0] xfer_offset_out,
    output logic [31:0] xfer_count_out,
    output logic [15:0] xfer_chan_out,
    output logic xfer_order_out,
    // message arrival from transport
    input wire logic arr_valid_in,
    input wire logic [7:0] arr_ctrl_in,
    input wire logic [31:0] arr_addr_in,
    input wire logic [7:0] arr_len_in,
    input wire logic [7:0] arr_code_in,
    input wire logic [7:0] arr_proto_in,
    input wire logic [7:0] arr_rc_in,
    // upward indications
    output logic disp_valid_out,
    output tmr_pkg::msg_type_t disp_type_out,
    output logic tmf_ind_out,
    output logic [31:0] tmf_obj_out,
    output logic [7:0] tmf_func_out,
    output logic conf_valid_out,
    output tmr_pkg::svc_resp_t conf_resp_out
);
    import tmr_pkg::*;

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("address bus too narrow for the register map");
        end
    endgenerate

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic {ST_IDLE, ST_SEND} send_state_t;
    typedef struct packed {
        logic [31:0] prdata;        // read data latched at setup
        logic pready;               // high in the first access cycle
        logic pslverr;              // unmapped address
        send_state_t sst;           // send sequencer
        logic swap;                 // swap flag register
        svc_resp_t resp;            // service response register
        logic [15:0] dest;          // destination register
        logic [31:0] buf_addr;      // image location register
        logic [31:0] rpath;         // return path register
        logic [31:0] xoff;          // transfer offset
        logic [31:0] xcnt;          // transfer byte count
        logic [15:0] xchan;         // channel
        logic order;                // ordering flag
        logic [15:0] s_dest;        // snapshot for the send
        logic [31:0] s_addr;
        logic s_swap;
        logic [63:0] s_image;
        svc_resp_t send_result;     // outcome of last send
        logic disp_valid;
        msg_type_t disp_type;
        logic tmf_ind;
        logic [31:0] tmf_obj;
        logic [7:0] tmf_func;
        logic conf_valid;
        svc_resp_t conf_resp;
        logic [7:0] rx_ctrl;        // last received control
        logic [7:0] rx_len;         // last received length
        logic [7:0] drop_cnt;       // invalid messages seen
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // ****************************************************************
    // helpers
    // ****************************************************************
    logic [7:0] enc_rc;          // encoded return code of resp register
    svc_resp_t dec_resp;         // decoded return code of arrival
    logic rx_ok;                 // arrival passes validation
    msg_type_t rx_type;          // arrival class
    logic [7:0] dummy_rc;        // unused encode of arrival side
    svc_resp_t ack_resp;         // decoded transport return code

    rc_codec u_enc (
        .resp_in(st_ff.resp),
        .rc_in(send_rc_in),
        .rc_out(enc_rc),
        .resp_out(ack_resp)
    );

    rc_codec u_dec (
        .resp_in(SR_FAILURE),
        .rc_in(arr_rc_in),
        .rc_out(dummy_rc),
        .resp_out(dec_resp)
    );

    msg_classifier u_cls (
        .code_in(arr_code_in),
        .proto_in(arr_proto_in),
        .len_in(arr_len_in),
        .valid_out(rx_ok),
        .type_out(rx_type)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [7:0] woff;
        logic hit;
        logic [31:0] rd;
        logic access;
        woff = {paddr_in[7:2], 2'b00};
        hit = 1'b1;
        rd = 32'h0000_0000;
        access = psel_in && penable_in && st_ff.pready;
        nxt_st = st_ff;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        nxt_st.disp_valid = 1'b0;
        nxt_st.tmf_ind = 1'b0;
        nxt_st.conf_valid = 1'b0;
        // read mux and address decode
        case (woff)
            OFF_CTRL: rd[CTRL_SWAP_BIT] = st_ff.swap;
            OFF_RESP: rd[1:0] = st_ff.resp;
            OFF_DEST: rd[15:0] = st_ff.dest;
            OFF_BUF: rd = st_ff.buf_addr;
            OFF_RPATH: rd = st_ff.rpath;
            OFF_STAT: rd = {8'h00, st_ff.drop_cnt, 4'h0, st_ff.disp_type,
                            2'b00, st_ff.send_result, 3'b000, st_ff.sst};
            OFF_XOFF: rd = st_ff.xoff;
            OFF_XCNT: rd = st_ff.xcnt;
            OFF_XCHAN: rd = {15'h0000, st_ff.order, st_ff.xchan};
            OFF_RXINFO: rd = {st_ff.tmf_func, st_ff.rx_ctrl, st_ff.rx_len,
                              6'h00, st_ff.conf_resp};
            default: hit = 1'b0;
        endcase
        if (ADDR_W > 8 && paddr_in >= ADDR_W'(256)) begin
            hit = 1'b0;
        end
        // setup phase: answer ready on the first access cycle
        if (psel_in && !penable_in) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !hit;
            nxt_st.prdata = (hit && !pwrite_in) ? rd : 32'h0000_0000;
        end
        // writes land at the access edge
        if (access && pwrite_in && hit) begin
            case (woff)
                OFF_CTRL: nxt_st.swap = pwdata_in[CTRL_SWAP_BIT];
                OFF_RESP: nxt_st.resp = svc_resp_t'(pwdata_in[1:0]);
                OFF_DEST: nxt_st.dest = pwdata_in[15:0];
                OFF_BUF: nxt_st.buf_addr = pwdata_in;
                OFF_RPATH: nxt_st.rpath = pwdata_in;
                OFF_XOFF: nxt_st.xoff = pwdata_in;
                OFF_XCNT: nxt_st.xcnt = pwdata_in;
                OFF_XCHAN: begin
                    nxt_st.xchan = pwdata_in[15:0];
                    nxt_st.order = pwdata_in[XCHAN_ORDER_BIT];
                end
                default: nxt_st.swap = st_ff.swap;
            endcase
        end
        // send sequencer
        case (st_ff.sst)
            ST_IDLE: begin
                // start ignored while a send is outstanding
                if (access && pwrite_in && woff == OFF_CTRL && pwdata_in[CTRL_GO_BIT]) begin
                    nxt_st.sst = ST_SEND;
                    nxt_st.s_dest = st_ff.dest;
                    nxt_st.s_addr = st_ff.buf_addr;
                    // swap flag travels with the request
                    nxt_st.s_swap = pwdata_in[CTRL_SWAP_BIT];
                    nxt_st.s_image = {st_ff.rpath, enc_rc, TAG_ZERO,
                                      PROTO_RESP, MSG_CODE_TMF};
                end
            end
            ST_SEND: begin
                if (send_ack_in) begin
                    nxt_st.sst = ST_IDLE;
                    nxt_st.send_result = (ack_resp == SR_COMPLETE) ? SR_COMPLETE
                                                                   : SR_FAILURE;
                end
            end
            default: nxt_st.sst = ST_IDLE;
        endcase
        if (arr_valid_in) begin
            nxt_st.rx_ctrl = arr_ctrl_in;
            nxt_st.rx_len = arr_len_in;
            if (!rx_ok) begin
                nxt_st.drop_cnt = st_ff.drop_cnt + 8'h01;
            end else begin
                nxt_st.disp_valid = 1'b1;
                nxt_st.disp_type = rx_type;
                case (rx_type)
                    MT_ABORT_TASK, MT_ABORT_SET, MT_CLEAR_QUEUE,
                    MT_TGT_RESET, MT_CLEAR_ACA, MT_LU_RESET: begin
                        nxt_st.tmf_ind = 1'b1;
                        nxt_st.tmf_obj = arr_addr_in;
                        nxt_st.tmf_func = arr_proto_in;
                    end
                    MT_RESPONSE: begin
                        nxt_st.conf_valid = 1'b1;
                        nxt_st.conf_resp = dec_resp;
                    end
                    default: nxt_st.tmf_ind = 1'b0;
                endcase
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // outputs, all from the state register except the constant send_ctrl_out and send_len_out
    // ****************************************************************
    assign prdata_out = st_ff.prdata;
    assign pready_out = st_ff.pready;
    assign pslverr_out = st_ff.pslverr;
    assign send_req_out = (st_ff.sst == ST_SEND);
    assign send_ctrl_out = SEND_CTRL;
    assign send_dest_out = st_ff.s_dest;
    assign send_addr_out = st_ff.s_addr;
    assign send_len_out = RESP_LEN;
    assign send_swap_out = st_ff.s_swap;
    assign send_image_out = st_ff.s_image;
    assign xfer_offset_out = st_ff.xoff;
    assign xfer_count_out = st_ff.xcnt;
    assign xfer_chan_out = st_ff.xchan;
    assign xfer_order_out = st_ff.order;
    assign disp_valid_out = st_ff.disp_valid;
    assign disp_type_out = st_ff.disp_type;
    assign tmf_ind_out = st_ff.tmf_ind;
    assign tmf_obj_out = st_ff.tmf_obj;
    assign tmf_func_out = st_ff.tmf_func;
    assign conf_valid_out = st_ff.conf_valid;
    assign conf_resp_out = st_ff.conf_resp;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_resp_codes: assert property (send_req_out |-> send_image_out[7:0] == MSG_CODE_TMF
        && send_image_out[15:8] == PROTO_RESP) else $error("bad response codes");
    a_tag_zero: assert property (send_req_out |-> send_image_out[23:16] == TAG_ZERO)
        else $error("response tag not zero");
    a_rc_map: assert property ($rose(send_req_out) |->
        (send_image_out[31:24] == RC_INVALID) == ($past(st_ff.resp) == SR_REJECTED))
        else $error("return code mapping wrong");
    a_ctrl_zero: assert property (send_req_out |-> send_ctrl_out == SEND_CTRL)
        else $error("send control not zero");
    a_dest_copy: assert property ($rose(send_req_out) |->
        send_dest_out == $past(st_ff.dest)) else $error("destination not copied");
    a_send_len: assert property ($rose(send_req_out) |->
        send_len_out == RESP_LEN && send_addr_out == $past(st_ff.buf_addr))
        else $error("image location or length wrong");
    a_conf_decode: assert property (arr_valid_in && rx_ok && rx_type == MT_RESPONSE
        && arr_rc_in == RC_SUCCESS |=> conf_valid_out && conf_resp_out == SR_COMPLETE)
        else $error("response not decoded");
    a_tmf_ind: assert property (arr_valid_in && arr_code_in == MSG_CODE_TMF
        && arr_proto_in == PROTO_TGT_RESET && arr_len_in >= MIN_RX_LEN
        |=> tmf_ind_out && tmf_func_out == PROTO_TGT_RESET)
        else $error("task management indication missing");
    a_drop_quiet: assert property (arr_valid_in && !rx_ok |=>
        !disp_valid_out && !tmf_ind_out && !conf_valid_out)
        else $error("invalid message not dropped");
    a_rpath_fill: assert property ($rose(send_req_out) |->
        send_image_out[63:32] == $past(st_ff.rpath))
        else $error("return path not filled");
endmodule : task_mgmt_response_dispatch
`default_nettype wire

// file: shared/_unused_dummy_never.sv
// reserved shared file, holds no definitions

// file: verif/transport_model.sv
// transport layer stand-in that answers send requests
`timescale 1ns/100ps
`default_nettype none
module transport_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [3:0] dly_in,
    input wire logic [7:0] rc_val_in,
    output logic ack_out,
    output logic [7:0] rc_out
);
    logic [3:0] wait_ff; // cycles spent on this request
    // one ack pulse per request after a chosen delay
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_ff <= 4'h0;
            ack_out <= 1'b0;
        end else begin
            ack_out <= req_in && !ack_out && wait_ff == dly_in;
            wait_ff <= (req_in && !ack_out && wait_ff != dly_in) ? wait_ff + 4'h1 : 4'h0;
        end
    end
    // code only meaningful with ack, inverted otherwise
    assign rc_out = ack_out ? rc_val_in : ~rc_val_in;
endmodule : transport_model
`default_nettype wire

// file: verif/task_mgmt_response_dispatch_bench.sv
// self-checking bench of the response builder and dispatcher
`timescale 1ns/100ps
`default_nettype none
module task_mgmt_response_dispatch_bench;
    import tmr_pkg::*;
    logic clk, rst, psel, pen, pwr, rdy, err, req, swp, ack, arv;
    logic [7:0] pad, sctl, slen, src, arc, ap, al, ar, fn, actl;
    logic [31:0] pwd, prd, sadr, xo, xc, aad, obj, rd;
    logic [15:0] sdst, xch;
    logic [63:0] img;
    logic xor_o, dv, ti, cv, e;
    logic [3:0] dly;
    logic [7:0] rcv;
    msg_type_t dt;
    svc_resp_t cr;
    int num_errors = 0;
    int total_checks = 0;
    task_mgmt_response_dispatch i_task_mgmt_response_dispatch (.clk_in(clk), .rst_in(rst),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .send_req_out(req),
        .send_ctrl_out(sctl), .send_dest_out(sdst), .send_addr_out(sadr), .send_len_out(slen),
        .send_swap_out(swp), .send_image_out(img), .send_ack_in(ack), .send_rc_in(src),
        .xfer_offset_out(xo), .xfer_count_out(xc), .xfer_chan_out(xch), .xfer_order_out(xor_o),
        .arr_valid_in(arv), .arr_ctrl_in(actl), .arr_addr_in(aad), .arr_len_in(al),
        .arr_code_in(arc), .arr_proto_in(ap), .arr_rc_in(ar), .disp_valid_out(dv),
        .disp_type_out(dt), .tmf_ind_out(ti), .tmf_obj_out(obj), .tmf_func_out(fn),
        .conf_valid_out(cv), .conf_resp_out(cr));
    transport_model i_transport_model (.clk_in(clk), .rst_in(rst), .req_in(req),
        .dly_in(dly), .rc_val_in(rcv), .ack_out(ack), .rc_out(src));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare and count
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer after an idle edge, waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        pen <= 1'b0;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // one arrival pulse, returns when the answer pulses stand
    task arr(input logic [7:0] c, input logic [7:0] p, input logic [7:0] l, input logic [7:0] r);
        @(posedge clk);
        arv <= 1'b1;
        arc <= c;
        ap <= p;
        al <= l;
        ar <= r;
        actl <= ~p;
        aad <= {24'hA0B0C0, p};
        @(posedge clk);
        arv <= 1'b0;
        #1;
    endtask : arr
    // build and send a response for each service response
    task t_send;
        logic [7:0] rcs [3] = '{RC_INVALID, RC_SUCCESS, RC_FAILED};
        for (int i = 0; i < 3; i++) begin
            dly = 4'(i * 3);
            apb(1, OFF_RESP, 32'(i));
            apb(1, OFF_DEST, 32'h0000_1230 + 32'(i));
            apb(1, OFF_BUF, 32'h8000_0100);
            apb(1, OFF_RPATH, 32'hCAFE_0042);
            apb(1, OFF_CTRL, {30'h0, i[0], 1'b1});
            #1;
            chk(req, 1);
            chk(img, {32'hCAFE_0042, rcs[i], TAG_ZERO, 8'h03, 8'h83});
            chk(sctl, 8'h00);
            chk(sdst, 16'h1230 + 16'(i));
            chk({sadr, slen, 7'h0, swp}, {32'h8000_0100, 8'h08, 7'h0, i[0]});
            for (int k = 0; k < 40 && req === 1'b1; k++) @(posedge clk);
            #1;
            chk(req, 0);
        end
        $display("send test done");
    endtask : t_send
    // transfer parameters reach the transport side
    task t_xfer;
        apb(1, OFF_XOFF, 32'hFFFF_FFFC);
        apb(1, OFF_XCNT, 32'h8000_0001);
        apb(1, OFF_XCHAN, 32'h0001_BEEF);
        #1;
        chk(xo, 32'hFFFF_FFFC);
        chk(xc, 32'h8000_0001);
        chk({xor_o, xch}, {1'b1, 16'hBEEF});
        apb(0, OFF_XCHAN, 32'h0);
        chk(rd, 32'h0001_BEEF);
        apb(0, 8'h40, 32'h0);
        chk({e, rd}, {1'b1, 32'h0});
        $display("transfer test done");
    endtask : t_xfer
    // dispatch of every request code, a short drop, three responses
    task t_arrive;
        msg_type_t ty [6] = '{MT_ABORT_TASK, MT_ABORT_SET, MT_CLEAR_QUEUE,
            MT_TGT_RESET, MT_CLEAR_ACA, MT_LU_RESET};
        for (int i = 0; i < 6; i++) begin
            arr(8'h83, 8'h30 + 8'(i), 8'h08, 8'h00);
            chk({dv, ti, dt, fn, obj}, {2'b11, ty[i], 8'h30 + 8'(i), 32'hA0B0C030 + 32'(i)});
        end
        arr(8'h83, 8'h31, 8'h02, 8'h00);
        chk({dv, ti, cv}, 3'b000);
        arr(8'h83, 8'h36, 8'h08, 8'h00);
        chk({dv, ti, cv}, 3'b000);
        arr(MSG_CODE_STAT, 8'h00, 8'h08, 8'h00);
        chk({dv, ti, dt}, {2'b10, MT_STATUS});
        arr(MSG_CODE_CMD, 8'h00, 8'h08, 8'h00);
        chk({dv, ti, dt}, {2'b10, MT_COMMAND});
        arr(8'h83, 8'h03, 8'h08, RC_INVALID);
        chk({cv, dt, cr}, {1'b1, MT_RESPONSE, SR_REJECTED});
        arr(8'h83, 8'h03, 8'h08, RC_SUCCESS);
        chk({cv, cr}, {1'b1, SR_COMPLETE});
        arr(8'h83, 8'h03, 8'h08, RC_FAILED);
        chk({cv, cr}, {1'b1, SR_FAILURE});
        apb(0, OFF_RXINFO, 32'h0);
        chk(rd, 32'h35FC_0802);
        $display("arrival test done");
    endtask : t_arrive
    // counts, verdict and stop
    task end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        pad = 8'h00;
        pwd = 32'h0;
        arv = 1'b0;
        arc = 8'h00;
        ap = 8'h00;
        al = 8'h00;
        ar = 8'h00;
        actl = 8'h00;
        aad = 32'h0;
        dly = 4'h0;
        rcv = RC_SUCCESS;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_send;
        t_xfer;
        t_arrive;
        end_sim;
    end
    initial begin
        #200us;
        num_errors++;
        end_sim;
    end
endmodule : task_mgmt_response_dispatch_bench
`default_nettype wire
